// ### inc/vte_pkg.sv
// constants for the vram transfer event scheduler
package vte_pkg;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned APB_AW     = 8;
  localparam int unsigned NUM_FM     = 2;
  localparam int unsigned NUM_SLOT   = 8;
  // per frame memory register word index (byte address = 4 * index)
  localparam logic [3:0]  IDX_CTRL   = 4'h0;
  localparam logic [3:0]  IDX_HBTP   = 4'h1;
  localparam logic [3:0]  IDX_HATP   = 4'h2;
  localparam logic [3:0]  IDX_HBST   = 4'h3;
  localparam logic [3:0]  IDX_HAEND  = 4'h4;
  localparam logic [3:0]  IDX_VBEND  = 4'h5;
  localparam logic [3:0]  IDX_VAST   = 4'h6;
  localparam logic [3:0]  IDX_VBST   = 4'h7;
  localparam logic [3:0]  IDX_VAEND  = 4'h8;
  localparam logic [3:0]  IDX_FSTART = 4'h9;
  localparam logic [3:0]  IDX_STRIDE = 4'ha;
  localparam logic [3:0]  IDX_MASK   = 4'hb;
  localparam logic [3:0]  IDX_CUR    = 4'hc;
  localparam logic [3:0]  IDX_NEXT   = 4'hd;
  localparam int unsigned NUM_CFG    = 12;
  localparam logic [7:0]  FM1_BASE   = 8'h40;
  localparam logic [7:0]  REG_FAULT  = 8'h80;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  // control word fields
  localparam int unsigned CTRL_UED   = 0;
  localparam int unsigned CTRL_EMS   = 1;
  localparam int unsigned CTRL_PTS   = 3;
  localparam int unsigned CTRL_CAPT  = 4;
  localparam int unsigned CTRL_ILACE = 5;
  localparam logic [1:0]  EMS_OFF      = 2'h0;
  localparam logic [1:0]  EMS_NO_LINE  = 2'h1;
  // linked-list start addresses for packet requests
  localparam logic [31:0] LL_FIELD_FM0 = 32'h0101_00e0;
  localparam logic [31:0] LL_OVF_FM0   = 32'h0101_00e4;
  localparam logic [31:0] LL_FIELD_FM1 = 32'h0101_00e8;
  localparam logic [31:0] LL_OVF_FM1   = 32'h0101_00ec;
  typedef enum logic [1:0] {
    KIND_FIELD = 2'h0,
    KIND_LINE  = 2'h1,
    KIND_EOF   = 2'h2,
    KIND_OVF   = 2'h3
  } vte_kind_t;
  typedef enum logic [1:0] {
    PKT_IDLE = 2'b01,
    PKT_BUSY = 2'b10
  } vte_pkt_t;
endpackage : vte_pkg

// ### core/vte_scheduler.sv
// vram row transfer event scheduler for two frame memories, apb slave
// What this block does
// - transfer point: horizontal_counter equals blank point, or area point under area control
// - if point equals blank start/area end, wait for that output low
// - field start: reset current address, request first line, load next address
// - select 0: field start at v_blank_end; noninterlaced also needs point
// - select 1: field start at v_area_start; noninterlaced also needs point
// - end of field only for capture and event mode 01
// - select 0: end of field at v_blank_start and blank point
// - select 1: end of field at v_area_end and area point
// - line event requests next line, then advances next address; active only
// - select 0: line event at blank point, none after vertical blanking
// - select 1: line event at area point, none after area inactive
// - overflow event when increment carries out of the tap mask field
// - each shift clock pulse adds the lowest one of the tap mask, except in a field start or line event cycle
// - packet select swaps row transfers for packet requests, same events
// - frame memory 0 packet lists at e0 (field) and e4 (overflow)
// - frame memory 1 packet lists at e8 (field) and ec (overflow)
// - faulting packet transfer ends at once, fault bits set, no suspend
// - list start address unchanged after a fault
// - subrow step is one bit above the top one of the tap mask
// - next address steps by stride, or twice stride when interlaced
// - same event on both memories: frame memory 0 first
`timescale 1ns/1ns
module vte_scheduler
  import vte_pkg::*;
(
  input  wire logic                        sys_clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [vte_pkg::APB_AW-1:0]  paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  input  wire logic [vte_pkg::CNT_W-1:0]   horizontal_counter0_i,
  input  wire logic [vte_pkg::CNT_W-1:0]   horizontal_counter1_i,
  input  wire logic [vte_pkg::CNT_W-1:0]   vertical_counter0_i,
  input  wire logic [vte_pkg::CNT_W-1:0]   vertical_counter1_i,
  input  wire logic [1:0]                  h_blank_output_n_i,
  input  wire logic [1:0]                  h_area_output_i,
  input  wire logic [1:0]                  odd_field_i,
  input  wire logic [1:0]                  serial_shift_clock_i,
  input  wire logic                        req_accept_i,
  input  wire logic                        pkt_done_i,
  input  wire logic                        pkt_fault_i,
  output logic                             req_valid_o,
  output logic                             req_fm_o,
  output logic      [1:0]                  req_kind_o,
  output logic                             req_packet_o,
  output logic      [vte_pkg::ADDR_W-1:0]  req_addr_o
);
  import vte_pkg::*;

  function automatic logic [31:0] lowest_one(input logic [31:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 31; i >= 0; i--) begin
      if (m[i]) begin
        r = 32'h0000_0001 << i;
      end
    end
    return r;
  endfunction : lowest_one

  function automatic logic [31:0] step_above(input logic [31:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 31; i++) begin
      if (m[i]) begin
        r = 32'h0000_0001 << (i + 1);
      end
    end
    return r;
  endfunction : step_above

  // lowest set bit wins: slot = kind * 2 + frame memory
  function automatic logic [2:0] pick_slot(input logic [7:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (p[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : pick_slot

  logic [31:0]       cfg_ff   [NUM_FM][NUM_CFG];
  logic [31:0]       cur_ff   [NUM_FM];
  logic [31:0]       next_ff  [NUM_FM];
  logic [31:0]       slot_addr_ff [NUM_SLOT];
  logic [7:0]        pend_ff;
  logic [7:0]        fault_ff;
  logic [NUM_FM-1:0] in_field_ff;
  logic [NUM_FM-1:0] fs_prev_ff;
  logic [NUM_FM-1:0] ln_prev_ff;
  logic [NUM_FM-1:0] eof_prev_ff;
  vte_pkt_t          pkt_state_ff;
  logic [2:0]        busy_slot_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic              req_valid_ff;
  logic [2:0]        req_slot_ff;
  logic              req_packet_ff;
  logic [31:0]       req_addr_ff;

  // apb decode; one wait state so read data leaves a flop
  wire        acc_phase = psel_i & penable_i;
  wire        acc_done  = acc_phase & pready_ff;
  wire        is_fault  = (paddr_i == REG_FAULT);
  wire        reg_fm    = paddr_i[6];
  wire [3:0]  reg_idx   = paddr_i[5:2];
  wire        in_fm     = ~paddr_i[7] & (paddr_i[1:0] == 2'h0)
                          & (reg_idx <= IDX_NEXT);
  wire        mapped    = in_fm | is_fault;
  wire        wr_en     = acc_done & pwrite_i & mapped;
  wire        wr_cfg    = wr_en & in_fm & (reg_idx < IDX_CUR);
  wire        wr_next   = wr_en & in_fm & (reg_idx == IDX_NEXT);
  wire        wr_fault  = wr_en & is_fault;
  wire [31:0] rd_fm     = (reg_idx == IDX_CUR)  ? cur_ff[reg_fm]  :
                          (reg_idx == IDX_NEXT) ? next_ff[reg_fm] :
                          cfg_ff[reg_fm][reg_idx];
  wire [31:0] rd_mux    = is_fault ? {24'h00_0000, fault_ff} :
                          in_fm ? rd_fm : 32'h0000_0000;

  // per frame memory event generation, fully independent
  logic [NUM_FM-1:0] fs_ev;
  logic [NUM_FM-1:0] ln_ev;
  logic [NUM_FM-1:0] eof_ev;
  logic [NUM_FM-1:0] ovf_ev;
  logic [NUM_FM-1:0] fs_raw;
  logic [NUM_FM-1:0] ln_raw;
  logic [NUM_FM-1:0] eof_raw;
  logic [NUM_FM-1:0] stop_hit;
  logic [31:0]       fsa      [NUM_FM];
  logic [31:0]       line_inc [NUM_FM];
  logic [31:0]       ovf_addr [NUM_FM];
  logic [31:0]       tap_inc  [NUM_FM];
  logic [NUM_FM-1:0] pkt_sel;

  for (genvar g = 0; g < NUM_FM; g++) begin : g_fm
    wire [CNT_W-1:0] hc    = (g == 0) ? horizontal_counter0_i
                                      : horizontal_counter1_i;
    wire [CNT_W-1:0] vc    = (g == 0) ? vertical_counter0_i
                                      : vertical_counter1_i;
    wire [31:0]      ctrl  = cfg_ff[g][IDX_CTRL];
    wire             unblanked_event_select   = ctrl[CTRL_UED];
    wire [1:0]       event_mode_field   = ctrl[CTRL_EMS +: 2];
    wire             ilace = ctrl[CTRL_ILACE];
    wire [CNT_W-1:0] hbtp  = cfg_ff[g][IDX_HBTP][CNT_W-1:0];
    wire [CNT_W-1:0] hatp  = cfg_ff[g][IDX_HATP][CNT_W-1:0];
    wire [CNT_W-1:0] vbst  = cfg_ff[g][IDX_VBST][CNT_W-1:0];
    wire [CNT_W-1:0] vaend = cfg_ff[g][IDX_VAEND][CNT_W-1:0];
    wire [31:0]      mask  = cfg_ff[g][IDX_MASK];
    wire [31:0]      strd  = cfg_ff[g][IDX_STRIDE];
    // hold off until blank/area output is low when point sits on the edge
    wire hb_hold = (hbtp == cfg_ff[g][IDX_HBST][CNT_W-1:0])
                   & h_blank_output_n_i[g];
    wire ha_hold = (hatp == cfg_ff[g][IDX_HAEND][CNT_W-1:0])
                   & h_area_output_i[g];
    wire hb_hit  = (hc == hbtp) & ~hb_hold;
    wire ha_hit  = (hc == hatp) & ~ha_hold;
    wire h_hit   = unblanked_event_select ? ha_hit : hb_hit;
    wire [CNT_W-1:0] v_first = unblanked_event_select ? cfg_ff[g][IDX_VAST][CNT_W-1:0]
                                   : cfg_ff[g][IDX_VBEND][CNT_W-1:0];
    wire [CNT_W-1:0] v_last  = unblanked_event_select ? vaend : vbst;
    wire [CNT_W-1:0] v_stop  = unblanked_event_select ? CNT_W'(vaend + 1'b1) : vbst;
    // interlaced fields need no horizontal qualifier
    assign fs_raw[g]   = (vc == v_first) & (ilace | h_hit);
    assign eof_raw[g]  = (vc == v_last) & h_hit;
    assign stop_hit[g] = (vc == v_stop);
    // no line event for lines starting after the active region
    assign ln_raw[g]   = h_hit & in_field_ff[g] & ~stop_hit[g]
                         & ~fs_raw[g];
    // counters may dwell several clocks, so fire once on the rising match
    assign fs_ev[g]  = fs_raw[g] & ~fs_prev_ff[g]
                       & (event_mode_field != EMS_OFF);
    assign ln_ev[g]  = ln_raw[g] & ~ln_prev_ff[g]
                       & event_mode_field[1];
    assign eof_ev[g] = eof_raw[g] & ~eof_prev_ff[g]
                       & (event_mode_field == EMS_NO_LINE)
                       & ctrl[CTRL_CAPT];
    assign tap_inc[g] = lowest_one(mask);
    assign ovf_ev[g] = serial_shift_clock_i[g] & event_mode_field[0] & (mask != 0)
                       & ((cur_ff[g] & mask) == mask);
    assign ovf_addr[g] = (cur_ff[g] & ~mask)
                         + step_above(mask);
    assign line_inc[g] = ilace ? {strd[30:0], 1'b0} : strd;
    assign fsa[g] = cfg_ff[g][IDX_FSTART]
                    + ((ilace & odd_field_i[g]) ? strd : 32'h0000_0000);
    assign pkt_sel[g] = ctrl[CTRL_PTS];
  end : g_fm

  // packet requests: timing events use the field list, overflow its own
  wire [31:0] ll_field [NUM_FM];
  wire [31:0] ll_ovf   [NUM_FM];
  assign ll_field[0] = LL_FIELD_FM0;
  assign ll_ovf[0]   = LL_OVF_FM0;
  assign ll_field[1] = LL_FIELD_FM1;
  assign ll_ovf[1]   = LL_OVF_FM1;

  wire [7:0] ev_set = {ovf_ev, eof_ev, ln_ev, fs_ev};
  logic [31:0] ev_addr [NUM_SLOT];
  for (genvar g = 0; g < NUM_FM; g++) begin : g_addr
    assign ev_addr[g]     = pkt_sel[g] ? ll_field[g] : fsa[g];
    assign ev_addr[2 + g] = pkt_sel[g] ? ll_field[g] : next_ff[g];
    assign ev_addr[4 + g] = pkt_sel[g] ? ll_field[g] : cur_ff[g];
    assign ev_addr[6 + g] = pkt_sel[g] ? ll_ovf[g]   : ovf_addr[g];
  end : g_addr

  // request channel: load a winner when the holding stage is free
  wire       pkt_idle  = (pkt_state_ff == PKT_IDLE);
  wire       stage_free = ~req_valid_ff | req_accept_i;
  wire [2:0] win       = pick_slot(pend_ff);
  wire       can_load  = stage_free & (pend_ff != 8'h00) & pkt_idle
                         & ~(req_valid_ff & req_packet_ff);
  wire [7:0] take      = can_load ? (8'h01 << win) : 8'h00;
  wire       win_pkt   = pkt_sel[win[0]];
  wire       pkt_acc   = req_valid_ff & req_accept_i & req_packet_ff;
  wire       pkt_fault = (pkt_state_ff == PKT_BUSY) & pkt_fault_i;
  wire [7:0] fault_set = pkt_fault ? (8'h01 << busy_slot_ff) : 8'h00;

  vte_pkt_t nxt_pkt_state;
  always_comb begin
    case (pkt_state_ff)
      PKT_IDLE: nxt_pkt_state = pkt_acc ? PKT_BUSY : PKT_IDLE;
      // fault ends the transfer at once, nothing kept for resume
      PKT_BUSY: nxt_pkt_state = (pkt_done_i | pkt_fault_i)
                                ? PKT_IDLE : PKT_BUSY;
      default:  nxt_pkt_state = PKT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc_phase & ~pready_ff;
      pslverr_ff <= acc_phase & ~pready_ff & ~mapped;
      prdata_ff  <= (acc_phase & ~pready_ff & ~pwrite_i) ? rd_mux
                                                         : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int f = 0; f < NUM_FM; f++) begin
      for (int r = 0; r < NUM_CFG; r++) begin
        if (reset_i) begin
          cfg_ff[f][r] <= CFG_RST;
        end else if (wr_cfg & (reg_fm == f[0]) & (reg_idx == 4'(r))) begin
          cfg_ff[f][r] <= pwdata_i;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int f = 0; f < NUM_FM; f++) begin
      if (reset_i) begin
        cur_ff[f]      <= CFG_RST;
        next_ff[f]     <= CFG_RST;
        in_field_ff[f] <= 1'b0;
        fs_prev_ff[f]  <= 1'b0;
        ln_prev_ff[f]  <= 1'b0;
        eof_prev_ff[f] <= 1'b0;
      end else begin
        fs_prev_ff[f]  <= fs_raw[f];
        ln_prev_ff[f]  <= ln_raw[f];
        eof_prev_ff[f] <= eof_raw[f];
        if (fs_ev[f]) begin
          in_field_ff[f] <= 1'b1;
        end else if (stop_hit[f]) begin
          in_field_ff[f] <= 1'b0;
        end
        if (fs_ev[f]) begin
          cur_ff[f]  <= fsa[f];
          next_ff[f] <= fsa[f] + line_inc[f];
        end else if (ln_ev[f]) begin
          cur_ff[f]  <= next_ff[f];
          next_ff[f] <= next_ff[f] + line_inc[f];
        end else begin
          if (serial_shift_clock_i[f]) begin
            cur_ff[f] <= cur_ff[f] + tap_inc[f];
          end
          if (wr_next & (reg_fm == f[0])) begin
            next_ff[f] <= pwdata_i;
          end
        end
      end
    end
  end

  // pending flags: a new event beats the clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pend_ff  <= 8'h00;
      fault_ff <= 8'h00;
    end else begin
      pend_ff  <= (pend_ff & ~take) | ev_set;
      fault_ff <= (fault_ff & ~(wr_fault ? pwdata_i[7:0] : 8'h00))
                  | fault_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int s = 0; s < NUM_SLOT; s++) begin
      if (reset_i) begin
        slot_addr_ff[s] <= CFG_RST;
      end else if (ev_set[s]) begin
        slot_addr_ff[s] <= ev_addr[s];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      req_valid_ff  <= 1'b0;
      req_slot_ff   <= 3'h0;
      req_packet_ff <= 1'b0;
      req_addr_ff   <= 32'h0000_0000;
    end else if (can_load) begin
      req_valid_ff  <= 1'b1;
      req_slot_ff   <= win;
      req_packet_ff <= win_pkt;
      req_addr_ff   <= slot_addr_ff[win];
    end else if (req_accept_i) begin
      req_valid_ff  <= 1'b0;
    end
  end

  // list pointer lives in memory; no retry address is ever advanced here
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pkt_state_ff <= PKT_IDLE;
      busy_slot_ff <= 3'h0;
    end else begin
      pkt_state_ff <= nxt_pkt_state;
      if (pkt_acc) begin
        busy_slot_ff <= req_slot_ff;
      end
    end
  end

  assign prdata_o     = prdata_ff;
  assign pready_o     = pready_ff;
  assign pslverr_o    = pslverr_ff;
  assign req_valid_o  = req_valid_ff;
  assign req_fm_o     = req_slot_ff[0];
  assign req_kind_o   = req_slot_ff[2:1];
  assign req_packet_o = req_packet_ff;
  assign req_addr_o   = req_addr_ff;
endmodule : vte_scheduler

// ### verification/vte_scheduler_checker.sv
// port-level assertions for the vram transfer event scheduler
`timescale 1ns/1ns
module vte_scheduler_checker
  import vte_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              reset_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              req_accept_i,
  input wire logic              req_valid_o,
  input wire logic              req_fm_o,
  input wire logic [1:0]        req_kind_o,
  input wire logic              req_packet_o,
  input wire logic [ADDR_W-1:0] req_addr_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic pkt_out;
  assign pkt_out = req_valid_o && req_packet_o;
  property p_ready_wait;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  property p_ready_in_access;
    pready_o |-> psel_i && penable_i;
  endproperty
  property p_rdata_idle;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  property p_err_ready;
    pslverr_o |-> pready_o;
  endproperty
  property p_req_hold;
    req_valid_o && !req_accept_i |=> req_valid_o && $stable(req_addr_o)
      && $stable({req_fm_o, req_kind_o, req_packet_o});
  endproperty
  property p_pkt_ovf_addr;
    pkt_out && req_kind_o == KIND_OVF
      |-> req_addr_o == (req_fm_o ? LL_OVF_FM1 : LL_OVF_FM0);
  endproperty
  property p_pkt_list_addr;
    pkt_out && req_kind_o != KIND_OVF
      |-> req_addr_o == (req_fm_o ? LL_FIELD_FM1 : LL_FIELD_FM0);
  endproperty
  property p_pkt_busy;
    pkt_out && req_accept_i |=> !req_valid_o [*3];
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("access not answered after one wait state");
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("ready outside an access phase");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero while idle");
  a_err_ready: assert property (p_err_ready)
    else $error("error flag without ready");
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before acceptance");
  a_pkt_ovf_addr: assert property (p_pkt_ovf_addr)
    else $error("wrong list address on overflow packet");
  a_pkt_list_addr: assert property (p_pkt_list_addr)
    else $error("wrong list address on field packet");
  a_pkt_busy: assert property (p_pkt_busy)
    else $error("request issued while packet transfer busy");
  c_field: cover property (req_valid_o && req_kind_o == KIND_FIELD);
  c_ovf: cover property (req_valid_o && req_kind_o == KIND_OVF);
  c_pkt: cover property (pkt_out && req_accept_i);
  c_err: cover property (pslverr_o);
endmodule : vte_scheduler_checker

bind vte_scheduler vte_scheduler_checker u_chk (.sys_clk_i, .reset_i,
  .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .req_accept_i,
  .req_valid_o, .req_fm_o, .req_kind_o, .req_packet_o, .req_addr_o);

// ### verification/vte_xfer_ctrl_model.sv
// behavioural transfer controller taking the scheduler's requests
`timescale 1ns/1ns
module vte_xfer_ctrl_model (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic req_valid_i,
  input  wire logic req_packet_i,
  input  wire logic stall_i,
  input  wire logic fault_cmd_i,
  output logic      req_accept_o,
  output logic      pkt_done_o,
  output logic      pkt_fault_o
);
  logic       busy_ff;
  logic [1:0] cnt_ff;
  // slow answers come from the bench holding stall
  assign req_accept_o = req_valid_i && !stall_i && !busy_ff;
  always_ff @(posedge sys_clk_i) begin
    pkt_done_o  <= 1'b0;
    pkt_fault_o <= 1'b0;
    if (reset_i) begin
      busy_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end else if (req_accept_o && req_packet_i) begin
      busy_ff <= 1'b1;
      cnt_ff  <= 2'h3;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 2'h1;
      if (cnt_ff == 2'h1) begin
        busy_ff     <= 1'b0;
        pkt_done_o  <= !fault_cmd_i;
        pkt_fault_o <= fault_cmd_i;
      end
    end
  end
endmodule : vte_xfer_ctrl_model

// ### verification/vte_scheduler_tb.sv
// self-checking bench for the vram transfer event scheduler
`timescale 1ns/1ns
module vte_scheduler_tb;
  import vte_pkg::*;
  localparam logic [31:0] FS = 32'h0200_0000;
  localparam logic [31:0] ST = 32'h0000_1000;
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, req_addr;
  logic        pready, pslverr, err, accept, done, fault;
  logic        stall = 1'b0, fcmd = 1'b0, req_valid, req_fm, req_packet;
  logic [1:0]  req_kind, sclk = 2'b00, hbn = 2'b00;
  logic [15:0] hc [2] = '{16'h0, 16'h0};
  logic [15:0] vc [2] = '{16'h0, 16'h0};
  logic [31:0] cfg [12] = '{32'h0, 32'h64, 32'h6e, 32'h5a, 32'h5f,
    32'ha, 32'hc, 32'hc8, 32'hbe, FS, ST, 32'h38};
  int          failures = 0, total_checks = 0, cycles = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  vte_scheduler dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .horizontal_counter0_i(hc[0]), .horizontal_counter1_i(hc[1]),
    .vertical_counter0_i(vc[0]), .vertical_counter1_i(vc[1]),
    .h_blank_output_n_i(hbn), .h_area_output_i(2'b00),
    .odd_field_i(2'b00), .serial_shift_clock_i(sclk),
    .req_accept_i(accept), .pkt_done_i(done), .pkt_fault_i(fault),
    .req_valid_o(req_valid), .req_fm_o(req_fm), .req_kind_o(req_kind),
    .req_packet_o(req_packet), .req_addr_o(req_addr));

  vte_xfer_ctrl_model u_tc (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .req_valid_i(req_valid), .req_packet_i(req_packet),
    .stall_i(stall), .fault_cmd_i(fcmd), .req_accept_o(accept),
    .pkt_done_o(done), .pkt_fault_o(fault));

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  // fkp packs frame memory, kind and packet flag
  task automatic wait_req(input logic [3:0] fkp, input logic [31:0] a);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (!(req_valid === 1'b1 && accept === 1'b1) && n < 60);
    chk({27'h0, req_valid, req_fm, req_kind, req_packet}, {28'h1, fkp});
    chk(req_addr, a);
  endtask : wait_req

  task automatic trig(input int fm, input logic [15:0] v,
                      input logic [15:0] h);
    @(posedge sys_clk_i);
    vc[fm] <= v;
    @(posedge sys_clk_i);
    hc[fm] <= h;
    @(posedge sys_clk_i);
    hc[fm] <= 16'h0;
  endtask : trig

  task automatic pulse(input int fm, input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      sclk[fm] <= 1'b1;
      @(posedge sys_clk_i);
      sclk[fm] <= 1'b0;
    end
  endtask : pulse

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(8'h34, 32'h0);
    for (int f = 0; f < 2; f++)
      for (int i = 1; i < 12; i++) begin
        apb(1'b1, 8'(f * 64 + i * 4), cfg[i]);
        rd(8'(f * 64 + i * 4), cfg[i]);
      end
    apb(1'b1, 8'h30, 32'h1234);
    rd(8'h30, 32'h0);
    rd(8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h00, 32'h06);
    apb(1'b1, 8'h40, 32'h05);
    // both memories hit their field start on one edge
    @(posedge sys_clk_i);
    vc[0] <= 16'd10;
    vc[1] <= 16'd12;
    @(posedge sys_clk_i);
    hc[0] <= 16'd100;
    hc[1] <= 16'd110;
    @(posedge sys_clk_i);
    hc[0] <= 16'h0;
    hc[1] <= 16'h0;
    wait_req(4'b0000, FS);
    wait_req(4'b1000, FS);
    rd(8'h30, FS);
    rd(8'h34, FS + ST);
    stall <= 1'b1;
    trig(0, 16'd11, 16'd100);
    repeat (6) @(posedge sys_clk_i);
    stall <= 1'b0;
    wait_req(4'b0010, FS + ST);
    rd(8'h34, FS + 2 * ST);
    trig(0, 16'd200, 16'd100);
    repeat (6) @(posedge sys_clk_i);
    chk({31'h0, req_valid}, 32'h0);
    pulse(0, 3);
    rd(8'h30, FS + ST + 32'h18);
    pulse(0, 5);
    wait_req(4'b0110, FS + ST + 32'h40);
    fcmd <= 1'b1;
    apb(1'b1, 8'h00, 32'h0e);
    trig(0, 16'd10, 16'd100);
    wait_req(4'b0001, LL_FIELD_FM0);
    repeat (8) @(posedge sys_clk_i);
    rd(8'h80, 32'h1);
    apb(1'b1, 8'h80, 32'h1);
    rd(8'h80, 32'h0);
    fcmd <= 1'b0;
    trig(0, 16'd10, 16'd100);
    wait_req(4'b0001, LL_FIELD_FM0);
    apb(1'b1, 8'h40, 32'h0f);
    trig(1, 16'd12, 16'd110);
    wait_req(4'b1001, LL_FIELD_FM1);
    pulse(1, 8);
    wait_req(4'b1111, LL_OVF_FM1);
    apb(1'b1, 8'h00, 32'h12);
    trig(0, 16'd10, 16'd100);
    wait_req(4'b0000, FS);
    trig(0, 16'd200, 16'd100);
    wait_req(4'b0100, FS);
    // point on blank start: held until blanking output goes low
    apb(1'b1, 8'h0c, 32'h64);
    hbn[0] <= 1'b1;
    @(posedge sys_clk_i);
    vc[0] <= 16'd10;
    hc[0] <= 16'd100;
    repeat (6) @(posedge sys_clk_i);
    chk({31'h0, req_valid}, 32'h0);
    hbn[0] <= 1'b0;
    wait_req(4'b0000, FS);
    hc[0] <= 16'h0;
    end_of_test();
  end
endmodule : vte_scheduler_tb
